// ===== logic/ccss_top.sv
// How it works
// - mode 001 gives cpu clock input/2
// - prescaler phases each one input period
// - mode 011 drives cpu clock from pin
// - ext modes: pll free-runs unless watchdog disabled
// - watchdog on after reset, config bit 4
// - watchdog works only in ext modes
// - pll cycles count, input edges clear
// - sixteen pll cycles without edge: failure
// - failure selects pll clock, raises flag
// - failure sticks until next reset
// - watchdog off in ext modes: oscillator clock, pll off
// - other codes except 000: pll multiplies input clock
// - pll resyncs every F input edges
// - per-code pll divider and multiplier settings
`timescale 1ns/1ps
module ccss_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // pins
  input wire logic [2:0] clock_mode_pins_in,
  input wire logic clock_input_pin_in,
  // system configuration and pll macro
  input wire logic [ccss_pkg::SYS_CONFIG_W-1:0] system_config_register_in,
  input wire logic pll_edge_in,
  input wire logic irq_clear_in,
  // clock outputs
  output logic cpu_clk_out,
  output logic [2:0] clock_mode_out,
  output logic clock_failed_out,
  output logic owd_irq_out,
  output logic mode_reserved_out,
  // pll and oscillator control
  output logic pll_enable_out,
  output logic pll_free_run_out,
  output logic osc_amp_bypass_out,
  output logic [2:0] pll_in_div_out,
  output logic [6:0] pll_mult_out,
  output logic [2:0] pll_out_div_out,
  output logic pll_resync_out
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic in_lvl;
  logic in_prev;
  logic [2:0] mode_sync;

  ccss_sync #(.WIDTH(1)) u_clk_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(clock_input_pin_in),
    .level_out(in_lvl)
  );

  ccss_sync #(.WIDTH(3)) u_mode_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(clock_mode_pins_in),
    .level_out(mode_sync)
  );

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_prev <= 1'b0;
    end else begin
      in_prev <= in_lvl;
    end
  end

  logic in_edge;
  logic in_rise;
  assign in_edge = in_lvl ^ in_prev;
  assign in_rise = in_lvl & ~in_prev;

  // ****************************************
  // strap capture and mode state
  // ****************************************
  ccss_pkg::ccss_state_t st;
  ccss_pkg::ccss_state_t next_st;
  logic [2:0] mode;
  logic [2:0] strap_cnt;
  logic strap_done;
  logic owd_dis;
  logic wd_active;
  logic wd_fail;
  logic [3:0] wd_cnt;

  assign strap_done = (strap_cnt == ccss_pkg::STRAP_WAIT);
  assign owd_dis = system_config_register_in[ccss_pkg::OWD_DISABLE_BIT];

  // pins are caught only after the synchroniser has settled past release
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_cnt <= 3'h0;
      mode <= ccss_pkg::RST_MODE;
    end else if (st == ccss_pkg::ST_STRAP) begin
      if (strap_done) begin
        mode <= mode_sync;
      end else begin
        strap_cnt <= 3'(strap_cnt + 3'h1);
      end
    end
  end

  always_comb begin
    next_st = st;
    case (st)
      ccss_pkg::ST_STRAP: begin
        if (strap_done) begin
          if (mode_sync == ccss_pkg::MODE_PRESCALE ||
              mode_sync == ccss_pkg::MODE_DIRECT) begin
            next_st = ccss_pkg::ST_EXT;
          end else if (mode_sync == ccss_pkg::MODE_RESERVED) begin
            next_st = ccss_pkg::ST_HALT;
          end else begin
            next_st = ccss_pkg::ST_PLL;
          end
        end
      end
      ccss_pkg::ST_EXT: begin
        if (wd_fail) begin
          next_st = ccss_pkg::ST_FAILED;
        end
      end
      ccss_pkg::ST_FAILED: next_st = ccss_pkg::ST_FAILED;
      ccss_pkg::ST_PLL: next_st = ccss_pkg::ST_PLL;
      ccss_pkg::ST_HALT: next_st = ccss_pkg::ST_HALT;
      default: next_st = ccss_pkg::ST_STRAP;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= ccss_pkg::ST_STRAP;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // oscillator watchdog
  // ****************************************
  assign wd_active = (st == ccss_pkg::ST_EXT) && !owd_dis;
  assign wd_fail = wd_active && pll_edge_in && !in_edge &&
                   (wd_cnt == ccss_pkg::OWD_LAST);

  // an input edge wins over a pll cycle in the same clock
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_cnt <= 4'h0;
    end else if (!wd_active || in_edge) begin
      wd_cnt <= 4'h0;
    end else if (pll_edge_in) begin
      wd_cnt <= 4'(wd_cnt + 4'h1);
    end
  end

  // set wins over clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      owd_irq_out <= 1'b0;
    end else begin
      owd_irq_out <= wd_fail | (owd_irq_out & ~irq_clear_in);
    end
  end

  // ****************************************
  // cpu clock generation
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_clk_out <= ccss_pkg::RST_CPU_CLK;
    end else begin
      case (st)
        ccss_pkg::ST_EXT: begin
          if (mode == ccss_pkg::MODE_PRESCALE) begin
            if (in_rise) begin
              cpu_clk_out <= ~cpu_clk_out;
            end
          end else begin
            cpu_clk_out <= in_lvl;
          end
        end
        ccss_pkg::ST_PLL, ccss_pkg::ST_FAILED: begin
          if (pll_edge_in) begin
            cpu_clk_out <= ~cpu_clk_out;
          end
        end
        default: cpu_clk_out <= ccss_pkg::RST_CPU_CLK;
      endcase
    end
  end

  // ****************************************
  // pll settings and control
  // ****************************************
  logic [2:0] next_in_div;
  logic [6:0] next_mult;
  logic [2:0] next_out_div;
  logic [3:0] factor;

  always_comb begin
    next_in_div = ccss_pkg::IN_DIV_4;
    next_mult = ccss_pkg::MUL_64;
    next_out_div = ccss_pkg::OUT_DIV_4;
    factor = ccss_pkg::FACTOR_X4;
    case (mode)
      ccss_pkg::MODE_X4: begin
        factor = ccss_pkg::FACTOR_X4;
      end
      ccss_pkg::MODE_X3: begin
        next_mult = ccss_pkg::MUL_48;
        factor = ccss_pkg::FACTOR_X3;
      end
      ccss_pkg::MODE_X8: begin
        next_out_div = ccss_pkg::OUT_DIV_2;
        factor = ccss_pkg::FACTOR_X8;
      end
      ccss_pkg::MODE_X5: begin
        next_mult = ccss_pkg::MUL_40;
        next_out_div = ccss_pkg::OUT_DIV_2;
        factor = ccss_pkg::FACTOR_X5;
      end
      ccss_pkg::MODE_X10: begin
        next_in_div = ccss_pkg::IN_DIV_2;
        next_mult = ccss_pkg::MUL_40;
        next_out_div = ccss_pkg::OUT_DIV_2;
        factor = ccss_pkg::FACTOR_X10;
      end
      default: begin
        factor = ccss_pkg::FACTOR_X4;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pll_in_div_out <= ccss_pkg::IN_DIV_4;
      pll_mult_out <= ccss_pkg::MUL_64;
      pll_out_div_out <= ccss_pkg::OUT_DIV_4;
    end else begin
      pll_in_div_out <= next_in_div;
      pll_mult_out <= next_mult;
      pll_out_div_out <= next_out_div;
    end
  end

  // in ext modes the pll only serves the watchdog; off saves supply current
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pll_enable_out <= 1'b0;
      pll_free_run_out <= 1'b0;
      osc_amp_bypass_out <= 1'b0;
      clock_failed_out <= 1'b0;
      mode_reserved_out <= 1'b0;
      clock_mode_out <= ccss_pkg::RST_MODE;
    end else begin
      pll_enable_out <= (st == ccss_pkg::ST_PLL) ||
                        (st == ccss_pkg::ST_FAILED) ||
                        (st == ccss_pkg::ST_EXT && !owd_dis);
      pll_free_run_out <= (st == ccss_pkg::ST_FAILED) ||
                          (st == ccss_pkg::ST_EXT && !owd_dis);
      osc_amp_bypass_out <= (st == ccss_pkg::ST_EXT) &&
                            (mode == ccss_pkg::MODE_DIRECT);
      clock_failed_out <= (st == ccss_pkg::ST_FAILED);
      mode_reserved_out <= (st == ccss_pkg::ST_HALT);
      clock_mode_out <= mode;
    end
  end

  // ****************************************
  // pll resynchronisation every F input edges
  // ****************************************
  logic [3:0] rs_cnt;
  logic rs_hit;
  assign rs_hit = (st == ccss_pkg::ST_PLL) && in_edge &&
                  (rs_cnt == 4'(factor - 4'h1));

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rs_cnt <= 4'h0;
      pll_resync_out <= 1'b0;
    end else begin
      pll_resync_out <= rs_hit;
      if (st != ccss_pkg::ST_PLL || rs_hit) begin
        rs_cnt <= 4'h0;
      end else if (in_edge) begin
        rs_cnt <= 4'(rs_cnt + 4'h1);
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_overflow;
    wd_active && pll_edge_in && !in_edge && wd_cnt == 4'hF;
  endsequence

  sequence s_failed_now;
    st == ccss_pkg::ST_FAILED && owd_irq_out;
  endsequence

  a_prescale_toggle: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == ccss_pkg::ST_EXT && mode == ccss_pkg::MODE_PRESCALE && in_rise)
    |=> cpu_clk_out != $past(cpu_clk_out))
    else $error("prescaler did not toggle on input rise");

  a_prescale_hold: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == ccss_pkg::ST_EXT && mode == ccss_pkg::MODE_PRESCALE &&
     !in_rise && $past(st) == ccss_pkg::ST_EXT)
    |=> $stable(cpu_clk_out))
    else $error("prescaler phase changed without input rise");

  a_direct_follow: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == ccss_pkg::ST_EXT && mode == ccss_pkg::MODE_DIRECT)
    |=> cpu_clk_out == $past(in_lvl) && osc_amp_bypass_out)
    else $error("direct drive does not follow input");

  a_pll_off_dis: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == ccss_pkg::ST_EXT && owd_dis) |=> !pll_enable_out)
    else $error("pll powered while watchdog disabled");

  a_wdog_count: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (wd_active && pll_edge_in && !in_edge && wd_cnt != 4'hF &&
     next_st == ccss_pkg::ST_EXT)
    |=> wd_cnt == $past(wd_cnt) + 4'h1)
    else $error("watchdog counter did not advance");

  a_wdog_clear: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (wd_active && in_edge) |=> wd_cnt == 4'h0)
    else $error("input edge did not clear watchdog");

  a_fail_switch: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_overflow |=> s_failed_now ##1 clock_failed_out)
    else $error("overflow did not switch to pll clock");

  a_fail_sticky: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    st == ccss_pkg::ST_FAILED |=> (st == ccss_pkg::ST_FAILED) [*8])
    else $error("failure state was left");

  a_no_wd_pll: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    st == ccss_pkg::ST_PLL |-> wd_cnt == 4'h0 && !wd_fail)
    else $error("watchdog active in pll mode");

  a_pll_resync: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == ccss_pkg::ST_PLL && in_edge &&
     rs_cnt == 4'(factor - 4'h1)) |=> pll_resync_out && rs_cnt == 4'h0)
    else $error("pll resync pulse missing");

  a_pll_mult: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == ccss_pkg::ST_PLL && $past(st) == ccss_pkg::ST_PLL &&
     mode == ccss_pkg::MODE_X3)
    |-> pll_mult_out == 7'h30 && pll_out_div_out == 3'h4)
    else $error("x3 pll settings wrong");

  a_mode_held: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    st != ccss_pkg::ST_STRAP |=> $stable(mode))
    else $error("clock mode changed after strap");

  a_irq_set_wins: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (wd_fail && irq_clear_in) |=> owd_irq_out)
    else $error("clear beat watchdog interrupt set");

endmodule : ccss_top

// ===== logic/ccss_pkg.sv
package ccss_pkg;

  // ****************************************
  // mode codes sampled from the strap pins
  // ****************************************
  localparam logic [2:0] MODE_X4 = 3'h7;
  localparam logic [2:0] MODE_X3 = 3'h6;
  localparam logic [2:0] MODE_X8 = 3'h5;
  localparam logic [2:0] MODE_X5 = 3'h4;
  localparam logic [2:0] MODE_DIRECT = 3'h3;
  localparam logic [2:0] MODE_X10 = 3'h2;
  localparam logic [2:0] MODE_PRESCALE = 3'h1;
  localparam logic [2:0] MODE_RESERVED = 3'h0;

  // ****************************************
  // pll divider and multiplier settings
  // ****************************************
  localparam logic [2:0] IN_DIV_2 = 3'h2;
  localparam logic [2:0] IN_DIV_4 = 3'h4;
  localparam logic [2:0] OUT_DIV_2 = 3'h2;
  localparam logic [2:0] OUT_DIV_4 = 3'h4;
  localparam logic [6:0] MUL_40 = 7'h28;
  localparam logic [6:0] MUL_48 = 7'h30;
  localparam logic [6:0] MUL_64 = 7'h40;
  localparam logic [3:0] FACTOR_X3 = 4'h3;
  localparam logic [3:0] FACTOR_X4 = 4'h4;
  localparam logic [3:0] FACTOR_X5 = 4'h5;
  localparam logic [3:0] FACTOR_X8 = 4'h8;
  localparam logic [3:0] FACTOR_X10 = 4'hA;

  // ****************************************
  // oscillator watchdog
  // ****************************************
  localparam int SYS_CONFIG_W = 16;
  localparam int OWD_DISABLE_BIT = 4;
  localparam int OWD_OVERFLOW = 16;
  localparam logic [3:0] OWD_LAST = 4'hF;

  // ****************************************
  // strap capture and reset values
  // ****************************************
  localparam logic [2:0] STRAP_WAIT = 3'h4;
  localparam logic [2:0] RST_MODE = MODE_X4;
  localparam logic RST_CPU_CLK = 1'b0;

  typedef enum logic [2:0] {
    ST_STRAP,
    ST_EXT,
    ST_PLL,
    ST_FAILED,
    ST_HALT
  } ccss_state_t;

endpackage : ccss_pkg

// ===== logic/ccss_sync.sv
`timescale 1ns/1ps
module ccss_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // asynchronous level in, filtered level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("ccss_sync: WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the second and third stage agree
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_out <= '0;
    end else if (stage2 == stage3) begin
      level_out <= stage3;
    end
  end

endmodule : ccss_sync

// ===== sim/ccss_osc_model.sv
`timescale 1ns/1ps
module ccss_osc_model (
  // clock
  input wire logic sys_clk_in,
  // run control
  input wire logic start_in,
  input wire logic [7:0] edges_in,
  input wire logic [3:0] half_in,
  // crystal side
  output logic pin_out,
  output logic busy_out
);
  // ****************************************
  // crystal model
  // ****************************************
  logic [7:0] left;
  logic [3:0] tick;

  initial begin
    pin_out = 1'b0;
    busy_out = 1'b0;
    left = 8'h00;
    tick = 4'h0;
  end

  // a stopped crystal holds its last level: that is the failure to catch
  always @(posedge sys_clk_in) begin
    if (start_in === 1'b1) begin
      left <= edges_in;
      tick <= 4'h1;
      busy_out <= (edges_in != 8'h00);
    end else if (busy_out) begin
      if (tick == half_in) begin
        pin_out <= ~pin_out;
        tick <= 4'h1;
        left <= left - 8'h01;
        busy_out <= (left != 8'h01);
      end else begin
        tick <= tick + 4'h1;
      end
    end
  end
endmodule : ccss_osc_model

// ===== sim/ccss_top_tb.sv
`timescale 1ns/1ps
module ccss_top_tb;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk_in, reset_n_in, clock_input_pin_in, pll_edge_in;
  logic irq_clear_in, cpu_clk_out, clock_failed_out, owd_irq_out;
  logic mode_reserved_out, pll_enable_out, pll_free_run_out;
  logic osc_amp_bypass_out, pll_resync_out, osc_start, osc_busy;
  logic [2:0] clock_mode_pins_in, clock_mode_out, pll_in_div_out;
  logic [2:0] pll_out_div_out;
  logic [6:0] pll_mult_out;
  logic [ccss_pkg::SYS_CONFIG_W-1:0] system_config_register_in;
  logic [7:0] osc_edges;
  logic [3:0] osc_half;
  int failures, samples_checked, n_cpu, n_rs, bad_gap, exp_gap;

  ccss_top ccss_top_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .clock_mode_pins_in(clock_mode_pins_in),
    .clock_input_pin_in(clock_input_pin_in),
    .system_config_register_in(system_config_register_in),
    .pll_edge_in(pll_edge_in), .irq_clear_in(irq_clear_in),
    .cpu_clk_out(cpu_clk_out), .clock_mode_out(clock_mode_out),
    .clock_failed_out(clock_failed_out), .owd_irq_out(owd_irq_out),
    .mode_reserved_out(mode_reserved_out),
    .pll_enable_out(pll_enable_out), .pll_free_run_out(pll_free_run_out),
    .osc_amp_bypass_out(osc_amp_bypass_out),
    .pll_in_div_out(pll_in_div_out), .pll_mult_out(pll_mult_out),
    .pll_out_div_out(pll_out_div_out), .pll_resync_out(pll_resync_out));

  ccss_osc_model ccss_osc_model_i (
    .sys_clk_in(sys_clk_in), .start_in(osc_start), .edges_in(osc_edges),
    .half_in(osc_half), .pin_out(clock_input_pin_in), .busy_out(osc_busy));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cycles

  task automatic reset_dut(input logic [2:0] mode);
    @(negedge sys_clk_in);
    reset_n_in = 1'b0;
    clock_mode_pins_in = mode;
    cycles(2);
    chk(clock_mode_out === 3'h7 && pll_mult_out === 7'h40, "reset state");
    cycles(10);
    reset_n_in = 1'b1;
    cycles(8);
  endtask : reset_dut

  task automatic osc_run(input logic [7:0] n, input logic [3:0] half);
    int k;
    osc_edges = n;
    osc_half = half;
    osc_start = 1'b1;
    cycles(1);
    osc_start = 1'b0;
    k = 0;
    while (osc_busy === 1'b1 && k < 2000) begin
      cycles(1);
      k++;
    end
    if (k >= 2000) begin
      failures++;
      $display("wrong value at %0t: oscillator hang", $time);
      final_report();
    end
    cycles(8);
  endtask : osc_run

  task automatic pll_pulses(input int n);
    repeat (n) begin
      pll_edge_in = 1'b1;
      cycles(1);
    end
    pll_edge_in = 1'b0;
    cycles(4);
  endtask : pll_pulses

  // counts cpu clock toggles and resync pulses; checks phase lengths
  task automatic observe(input int cyc);
    logic pc;
    int gap;
    n_cpu = 0;
    n_rs = 0;
    bad_gap = 0;
    gap = -1;
    pc = cpu_clk_out;
    repeat (cyc) begin
      @(negedge sys_clk_in);
      if (gap >= 0) gap++;
      if (pll_resync_out === 1'b1) n_rs++;
      if (cpu_clk_out !== pc) begin
        n_cpu++;
        if (gap > 0 && exp_gap > 0 && gap != exp_gap) bad_gap++;
        gap = 0;
      end
      pc = cpu_clk_out;
    end
  endtask : observe

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_prescale;
    reset_dut(ccss_pkg::MODE_PRESCALE);
    exp_gap = 6;
    chk(osc_amp_bypass_out === 1'b0, "bypass in prescale");
    chk(pll_enable_out === 1'b1, "pll off at reset default");
    clock_mode_pins_in = ccss_pkg::MODE_DIRECT;
    fork
      observe(120);
      osc_run(8'h10, 4'h3);
    join
    chk(n_cpu == 8, "prescale toggle count");
    chk(bad_gap == 0, "prescale phase length");
    chk(clock_mode_out === ccss_pkg::MODE_PRESCALE, "mode moved");
    $display("test prescale done");
  endtask : t_prescale

  task automatic t_direct;
    reset_dut(ccss_pkg::MODE_DIRECT);
    exp_gap = 4;
    chk(osc_amp_bypass_out === 1'b1, "no bypass in direct");
    fork
      observe(100);
      osc_run(8'h0C, 4'h4);
    join
    chk(n_cpu == 12 && bad_gap == 0, "direct drive follow");
    system_config_register_in[ccss_pkg::OWD_DISABLE_BIT] = 1'b1;
    cycles(3);
    chk(pll_enable_out === 1'b0, "pll on while disabled");
    pll_pulses(20);
    chk(clock_failed_out === 1'b0 && owd_irq_out === 1'b0, "fail off");
    system_config_register_in[ccss_pkg::OWD_DISABLE_BIT] = 1'b0;
    cycles(3);
    chk(pll_enable_out === 1'b1, "pll off while enabled");
    $display("test direct done");
  endtask : t_direct

  task automatic t_pll;
    logic [2:0] code [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2};
    logic [2:0] ind [5] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h2};
    logic [6:0] mul [5] = '{7'h40, 7'h30, 7'h40, 7'h28, 7'h28};
    logic [2:0] od [5] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h2};
    int fac [5] = '{4, 3, 8, 5, 10};
    exp_gap = 0;
    for (int i = 0; i < 5; i++) begin
      reset_dut(code[i]);
      chk(pll_in_div_out === ind[i] && pll_mult_out === mul[i]
          && pll_out_div_out === od[i], "pll settings");
      chk(pll_enable_out === 1'b1, "pll off in pll mode");
      fork
        observe(40);
        pll_pulses(20);
      join
      chk(n_cpu == 20, "pll toggle count");
      chk(clock_failed_out === 1'b0 && owd_irq_out === 1'b0, "wd");
      fork
        observe(200);
        osc_run(8'(2 * fac[i]), 4'h3);
      join
      chk(n_rs == 2, "resync count");
    end
    reset_dut(ccss_pkg::MODE_RESERVED);
    fork
      observe(60);
      osc_run(8'h08, 4'h3);
    join
    chk(mode_reserved_out === 1'b1 && n_cpu == 0, "reserved mode");
    $display("test pll done");
  endtask : t_pll

  task automatic t_watchdog;
    reset_dut(ccss_pkg::MODE_DIRECT);
    pll_pulses(15);
    chk(clock_failed_out === 1'b0 && owd_irq_out === 1'b0, "early");
    osc_run(8'h01, 4'h3);
    pll_pulses(15);
    chk(clock_failed_out === 1'b0, "count not cleared");
    // clear lands on the overflow cycle: the set must still win
    pll_edge_in = 1'b1;
    irq_clear_in = 1'b1;
    cycles(1);
    pll_edge_in = 1'b0;
    irq_clear_in = 1'b0;
    cycles(4);
    chk(owd_irq_out === 1'b1 && clock_failed_out === 1'b1, "no fail");
    chk(pll_free_run_out === 1'b1 && pll_enable_out === 1'b1, "pll");
    fork
      observe(20);
      pll_pulses(6);
    join
    chk(n_cpu == 6, "backup clock toggles");
    fork
      observe(80);
      osc_run(8'h07, 4'h3);
    join
    chk(n_cpu == 0 && clock_failed_out === 1'b1, "switched back");
    irq_clear_in = 1'b1;
    cycles(1);
    irq_clear_in = 1'b0;
    cycles(2);
    chk(owd_irq_out === 1'b0 && clock_failed_out === 1'b1, "clear");
    reset_dut(ccss_pkg::MODE_DIRECT);
    chk(clock_failed_out === 1'b0 && owd_irq_out === 1'b0, "kept");
    $display("test watchdog done");
  endtask : t_watchdog

  initial begin
    reset_n_in = 1'b0;
    clock_mode_pins_in = ccss_pkg::MODE_X4;
    system_config_register_in = '0;
    pll_edge_in = 1'b0;
    irq_clear_in = 1'b0;
    osc_start = 1'b0;
    osc_edges = 8'h00;
    osc_half = 4'h3;
    failures = 0;
    samples_checked = 0;
    exp_gap = 0;
    t_prescale();
    t_direct();
    t_pll();
    t_watchdog();
    final_report();
  end
endmodule : ccss_top_tb
